// ===== hw/wtm_pkg.sv
/*
 Constants, register map and types for the waveform trigger and marker controller.
 Assumes one clock at the sample rate and a 32-bit AXI4-Lite register bus.
*/
// Notes on behaviour
// - Manual trigger command fires one internal trigger
// - Sync output aligns output start to trigger
// - Processing latency is readable by software
// - Delay unit selects samples or time, samples default
// - Sample delay with hundredth resolution, from zero; only whole samples applied
// - Time delay in ns, capped clock periods
// - Applied delay readable in quarter nanoseconds
// - Hold-off ignores restart triggers after restart
// - Five marker sources, waveform-defined by default
// - Waveform-defined marker follows stored marker bits
// - Duty marker alternates high and low periods
// - Pattern marker plays 1 to 64 bits
// - Pulse marker divides by 2 to 1024
// - Pulse frequency readable, rate over divisor
// - Marker start offset by programmed symbols
// - Marker delay readable in thousandths of microseconds
// - Clock source is internal only
// - Trigger mode selectable, auto by default
// - Arm stops output and awaits trigger
package wtm_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int AXI_AW = 8;
	localparam int PAT_W = 64;

	// Global register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_SAMPLE_DELAY = 8'h08;
	localparam logic [7:0] ADDR_TIME_UNIT_DELAY = 8'h0C;
	localparam logic [7:0] ADDR_HOLDOFF = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_PROCESSING_LATENCY = 8'h18;
	localparam logic [7:0] ADDR_APPLIED_LO = 8'h1C;
	localparam logic [7:0] ADDR_APPLIED_HI = 8'h20;
	// Marker channel c sits at (c + 1) * 0x40; word index in bits 5:2
	localparam logic [3:0] MKW_MODE = 4'h0;
	localparam logic [3:0] MKW_HIGH = 4'h1;
	localparam logic [3:0] MKW_LOW = 4'h2;
	localparam logic [3:0] MKW_PAT_LO = 4'h3;
	localparam logic [3:0] MKW_PAT_HI = 4'h4;
	localparam logic [3:0] MKW_PAT_LEN = 4'h5;
	localparam logic [3:0] MKW_DIVIDER = 4'h6;
	localparam logic [3:0] MKW_DELAY = 4'h7;
	localparam logic [3:0] MKW_PULSE_FREQ = 4'h8;
	localparam logic [3:0] MKW_DELAY_TIME = 4'h9;

	// Field positions
	localparam int CTRL_SYNC = 0;
	localparam int CTRL_UNIT_TIME = 1;
	localparam int CTRL_TMODE_LSB = 4;
	localparam int CTRL_CLKSRC = 8;
	localparam int CMD_TRIGGER = 0;
	localparam int CMD_ARM = 1;
	localparam int DLY_FRAC_W = 7;
	localparam int DLY_WHOLE_W = 25;

	// Reset values and limits
	localparam logic RST_SYNC = 1'b1;
	localparam logic CLKSRC_INTERNAL = 1'b0;
	localparam logic [31:0] FRAC_MAX = 32'h0000_0063;
	localparam logic [31:0] DLY_MAX_CYC = 32'h7FFF_FFFF;
	localparam logic [31:0] HOLDOFF_MAX_CYC = 32'((64'(CLK_HZ) * 64'd2147) / 64'd100);
	localparam logic [31:0] PERIOD_MIN = 32'h0000_0001;
	localparam logic [31:0] PERIOD_MAX = 32'h00E3_8E37;
	localparam logic [31:0] PAT_LEN_MIN = 32'h0000_0001;
	localparam logic [31:0] PAT_LEN_MAX = 32'h0000_0040;
	localparam logic [6:0] PAT_LEN_RST = 7'h02;
	localparam logic [63:0] PAT_RST = 64'h0000_0000_0000_0002;
	localparam logic [31:0] DIV_MIN = 32'h0000_0002;
	localparam logic [31:0] DIV_MAX = 32'h0000_0400;
	localparam int QNS_PER_CYC = CLK_PERIOD_NS * 4;
	localparam int QNS_PER_HUNDREDTH = QNS_PER_CYC / 100;
	localparam int OWN_LAT_CYC = 5;

	typedef enum logic [2:0] {
		MK_WAVEFORM_DEFINED, MK_RESTART, MK_PULSE, MK_PATTERN, MK_DUTY
	} wtm_mk_mode_t;
	localparam logic [2:0] MK_MODE_LAST = 3'h4;

	typedef enum logic [2:0] {
		TM_AUTO, TM_RETRIGGER, TM_ARMED_FREE_RUN, TM_ARMED_REARM, TM_SINGLE
	} wtm_trig_mode_t;
	localparam logic [2:0] TM_LAST = 3'h4;

	typedef enum logic [1:0] {ST_START, ST_ARMED, ST_RUN} wtm_play_state_t;
endpackage

// ===== hw/wtm_countdown.sv
/*
 Loadable down counter that decrements once per clock and pulses when it runs out.
 Assumes load and value come from logic on the same clock.
*/
`timescale 1ns/1ns
module wtm_countdown #(
	parameter int W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt;

	// A load always restarts the count, even while busy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			cnt <= '0;
		end else if (load) begin
			busy <= 1'b1;
			cnt <= value;
		end else if (busy) begin
			if (cnt == '0) begin
				busy <= 1'b0;
			end else begin
				cnt <= cnt - W'(1);
			end
		end
	end

	// Done comes value + 1 cycles after the load edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done <= 1'b0;
		end else begin
			done <= busy && !load && (cnt == '0);
		end
	end
endmodule

// ===== hw/wtm_marker.sv
/*
 One marker output generator with five sources and a start offset.
 Assumes restart and running come from the playback control on the same clock.
*/
`timescale 1ns/1ns
module wtm_marker #(
	parameter int PW = 24
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wtm_pkg::wtm_mk_mode_t mode,
	input wire logic [PW-1:0] high_period_samples,
	input wire logic [PW-1:0] low_period_samples,
	input wire logic [wtm_pkg::PAT_W-1:0] pattern,
	input wire logic [6:0] pat_len,
	input wire logic [10:0] divider,
	input wire logic [PW-1:0] start_delay,
	input wire logic restart,
	input wire logic running,
	input wire logic waveform_bit,
	output logic marker
);
	logic start;
	logic active;
	logic duty_hi;
	logic [PW-1:0] phase;
	logic [5:0] bit_idx;

	// Generated sources begin start_delay + 1 cycles after the restart
	wtm_countdown #(.W(PW)) u_start (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(restart),
		.value(start_delay),
		.busy(),
		.done(start)
	);

	// Generators stay quiet between a restart and the delayed start
	always_ff @(posedge aclk) begin
		if (!aresetn || restart || !running) begin
			active <= 1'b0;
		end else if (start) begin
			active <= 1'b1;
		end
	end

	// Phase counters; the pattern plays most significant used bit first
	always_ff @(posedge aclk) begin
		if (!aresetn || start) begin
			phase <= '0;
			duty_hi <= 1'b1;
			bit_idx <= 6'(pat_len - 7'd1);
		end else if (active && running) begin
			case (mode)
				wtm_pkg::MK_PULSE: begin
					phase <= (phase >= PW'(divider) - PW'(1)) ? '0 : phase + PW'(1);
				end
				wtm_pkg::MK_DUTY: begin
					if (phase >= (duty_hi ? high_period_samples : low_period_samples) - PW'(1)) begin
						phase <= '0;
						duty_hi <= !duty_hi;
					end else begin
						phase <= phase + PW'(1);
					end
				end
				wtm_pkg::MK_PATTERN: begin
					bit_idx <= (bit_idx == 6'h00) ? 6'(pat_len - 7'd1) : bit_idx - 6'h01;
				end
				default: begin
				end
			endcase
		end
	end

	// Registered marker level per source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			marker <= 1'b0;
		end else begin
			case (mode)
				wtm_pkg::MK_WAVEFORM_DEFINED: marker <= waveform_bit && running;
				wtm_pkg::MK_RESTART: marker <= start && running;
				wtm_pkg::MK_PULSE: marker <= active && running && (phase < PW'(divider >> 1));
				wtm_pkg::MK_DUTY: marker <= active && running && duty_hi;
				wtm_pkg::MK_PATTERN: marker <= active && running && pattern[bit_idx];
				default: marker <= 1'b0;
			endcase
		end
	end
endmodule

// ===== hw/wtm_top.sv
/*
 Trigger and marker controller for a waveform playback engine, with AXI4-Lite registers.
 Assumes aclk is the sample clock, the external trigger pin is asynchronous, and the
 waveform marker bits come from the playback memory on the same clock.
*/
`timescale 1ns/1ns
module wtm_top #(
	parameter int NMARK = 3,
	parameter int PIPE_LAT_NS = 0,
	parameter int SINGLE_LEN = 1024
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [wtm_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [wtm_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_trigger_pin,
	input wire logic [NMARK-1:0] waveform_defined_marker,
	output logic [NMARK-1:0] marker_out,
	output logic play_run,
	output logic play_restart
);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Settings
	logic sync_output_enable;
	logic unit_time;
	wtm_pkg::wtm_trig_mode_t trig_mode;
	logic [wtm_pkg::DLY_WHOLE_W-1:0] delay_whole;
	logic [wtm_pkg::DLY_FRAC_W-1:0] delay_frac;
	logic [31:0] time_unit_delay;
	logic [31:0] holdoff;
	wtm_pkg::wtm_mk_mode_t mk_mode [NMARK];
	logic [23:0] high_period_samples [NMARK];
	logic [23:0] low_period_samples [NMARK];
	logic [63:0] mk_pattern [NMARK];
	logic [6:0] mk_pat_len [NMARK];
	logic [10:0] mk_divider [NMARK];
	logic [23:0] mk_delay [NMARK];

	// Trigger path
	logic ext_meta;
	logic ext_sync;
	logic ext_prev;
	logic manual_cmd;
	logic arm_cmd;
	logic mode_write;
	logic dly_busy;
	logic dly_done;
	logic inh_busy;
	logic single_done;
	wtm_pkg::wtm_play_state_t state;
	wtm_pkg::wtm_play_state_t next_state;
	logic next_restart;
	logic [31:0] delay_cyc;
	logic [39:0] applied_delay_seconds;

	// Bus decode
	logic wr_fire;
	logic rd_fire;
	logic [31:0] wr_val;
	logic [1:0] wr_ch;
	logic [3:0] wr_idx;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		logic [1:0] c;
		c = a[7:6] - 2'h1;
		if (a[7:6] != 2'h0) begin
			return (int'(c) < NMARK) && (a[5:2] <= wtm_pkg::MKW_DELAY_TIME);
		end
		return {a[7:2], 2'h0} <= wtm_pkg::ADDR_APPLIED_HI;
	endfunction

	// Current content of any register word; command word reads as zero
	function automatic logic [31:0] word_at(input logic [7:0] a);
		logic [1:0] c;
		logic [31:0] r;
		c = a[7:6] - 2'h1;
		r = 32'h0000_0000;
		if (a[7:6] == 2'h0) begin
			case ({a[7:2], 2'h0})
				wtm_pkg::ADDR_CTRL: begin
					r[wtm_pkg::CTRL_SYNC] = sync_output_enable;
					r[wtm_pkg::CTRL_UNIT_TIME] = unit_time;
					r[wtm_pkg::CTRL_TMODE_LSB +: 3] = trig_mode;
					r[wtm_pkg::CTRL_CLKSRC] = wtm_pkg::CLKSRC_INTERNAL;
				end
				wtm_pkg::ADDR_SAMPLE_DELAY: r = {delay_whole, delay_frac};
				wtm_pkg::ADDR_TIME_UNIT_DELAY: r = time_unit_delay;
				wtm_pkg::ADDR_HOLDOFF: r = holdoff;
				wtm_pkg::ADDR_STATUS: r = {28'h000_0000, inh_busy, dly_busy,
					state == wtm_pkg::ST_ARMED, play_run};
				wtm_pkg::ADDR_PROCESSING_LATENCY:
					r = 32'(wtm_pkg::OWN_LAT_CYC * wtm_pkg::CLK_PERIOD_NS + PIPE_LAT_NS);
				wtm_pkg::ADDR_APPLIED_LO: r = applied_delay_seconds[31:0];
				wtm_pkg::ADDR_APPLIED_HI: r = {24'h00_0000, applied_delay_seconds[39:32]};
				default: r = 32'h0000_0000;
			endcase
		end else if (int'(c) < NMARK) begin
			case (a[5:2])
				wtm_pkg::MKW_MODE: r = {29'h0000_0000, mk_mode[c]};
				wtm_pkg::MKW_HIGH: r = {8'h00, high_period_samples[c]};
				wtm_pkg::MKW_LOW: r = {8'h00, low_period_samples[c]};
				wtm_pkg::MKW_PAT_LO: r = mk_pattern[c][31:0];
				wtm_pkg::MKW_PAT_HI: r = mk_pattern[c][63:32];
				wtm_pkg::MKW_PAT_LEN: r = {25'h000_0000, mk_pat_len[c]};
				wtm_pkg::MKW_DIVIDER: r = {21'h00_0000, mk_divider[c]};
				wtm_pkg::MKW_DELAY: r = {8'h00, mk_delay[c]};
				wtm_pkg::MKW_PULSE_FREQ: r = 32'(wtm_pkg::CLK_HZ) / {21'h00_0000, mk_divider[c]};
				wtm_pkg::MKW_DELAY_TIME:
					r = {8'h00, mk_delay[c]} * 32'(wtm_pkg::CLK_PERIOD_NS);
				default: r = 32'h0000_0000;
			endcase
		end
		return r;
	endfunction

	assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign rd_fire = s_axi_arready && s_axi_arvalid;
	assign wr_val = wmerge(word_at(s_axi_awaddr), s_axi_wdata, s_axi_wstrb);
	assign wr_ch = s_axi_awaddr[7:6] - 2'h1;
	assign wr_idx = s_axi_awaddr[5:2];

	// Write channel: address and data are taken together once both are offered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: data are captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= word_at(s_axi_araddr);
				s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Global settings; out-of-range mode codes are ignored, limits are clamped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_output_enable <= wtm_pkg::RST_SYNC;
			unit_time <= 1'b0;
			trig_mode <= wtm_pkg::TM_AUTO;
			delay_whole <= '0;
			delay_frac <= '0;
			time_unit_delay <= 32'h0000_0000;
			holdoff <= 32'h0000_0000;
		end else if (wr_fire && s_axi_awaddr[7:6] == 2'h0) begin
			case ({s_axi_awaddr[7:2], 2'h0})
				wtm_pkg::ADDR_CTRL: begin
					sync_output_enable <= wr_val[wtm_pkg::CTRL_SYNC];
					unit_time <= wr_val[wtm_pkg::CTRL_UNIT_TIME];
					if (wr_val[wtm_pkg::CTRL_TMODE_LSB +: 3] <= wtm_pkg::TM_LAST) begin
						trig_mode <= wtm_pkg::wtm_trig_mode_t'(wr_val[wtm_pkg::CTRL_TMODE_LSB +: 3]);
					end
				end
				wtm_pkg::ADDR_SAMPLE_DELAY: begin
					delay_whole <= wr_val[31:wtm_pkg::DLY_FRAC_W];
					delay_frac <= 7'(clamp({25'h000_0000, wr_val[6:0]}, 32'h0000_0000,
						wtm_pkg::FRAC_MAX));
				end
				wtm_pkg::ADDR_TIME_UNIT_DELAY: time_unit_delay <= wr_val;
				wtm_pkg::ADDR_HOLDOFF:
					holdoff <= clamp(wr_val, 32'h0000_0000, wtm_pkg::HOLDOFF_MAX_CYC);
				default: begin
				end
			endcase
		end
	end

	// Command pulses and mode-change detection, one cycle each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			manual_cmd <= 1'b0;
			arm_cmd <= 1'b0;
			mode_write <= 1'b0;
		end else begin
			manual_cmd <= wr_fire && s_axi_awaddr[7:2] == wtm_pkg::ADDR_CMD[7:2]
				&& s_axi_wstrb[0] && s_axi_wdata[wtm_pkg::CMD_TRIGGER];
			arm_cmd <= wr_fire && s_axi_awaddr[7:2] == wtm_pkg::ADDR_CMD[7:2]
				&& s_axi_wstrb[0] && s_axi_wdata[wtm_pkg::CMD_ARM];
			mode_write <= wr_fire && s_axi_awaddr[7:2] == wtm_pkg::ADDR_CTRL[7:2]
				&& wr_val[wtm_pkg::CTRL_TMODE_LSB +: 3] != trig_mode
				&& wr_val[wtm_pkg::CTRL_TMODE_LSB +: 3] <= wtm_pkg::TM_LAST;
		end
	end

	// Marker settings, one set per channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < NMARK; c++) begin
				mk_mode[c] <= wtm_pkg::MK_WAVEFORM_DEFINED;
				high_period_samples[c] <= 24'(wtm_pkg::PERIOD_MIN);
				low_period_samples[c] <= 24'(wtm_pkg::PERIOD_MIN);
				mk_pattern[c] <= wtm_pkg::PAT_RST;
				mk_pat_len[c] <= wtm_pkg::PAT_LEN_RST;
				mk_divider[c] <= 11'(wtm_pkg::DIV_MIN);
				mk_delay[c] <= 24'h00_0000;
			end
		end else if (wr_fire && s_axi_awaddr[7:6] != 2'h0) begin
			for (int c = 0; c < NMARK; c++) begin
				if (2'(c) == wr_ch) begin
					case (wr_idx)
						wtm_pkg::MKW_MODE: begin
							if (wr_val[2:0] <= wtm_pkg::MK_MODE_LAST) begin
								mk_mode[c] <= wtm_pkg::wtm_mk_mode_t'(wr_val[2:0]);
							end
						end
						wtm_pkg::MKW_HIGH: high_period_samples[c] <=
							24'(clamp(wr_val, wtm_pkg::PERIOD_MIN, wtm_pkg::PERIOD_MAX));
						wtm_pkg::MKW_LOW: low_period_samples[c] <=
							24'(clamp(wr_val, wtm_pkg::PERIOD_MIN, wtm_pkg::PERIOD_MAX));
						wtm_pkg::MKW_PAT_LO: mk_pattern[c][31:0] <= wr_val;
						wtm_pkg::MKW_PAT_HI: mk_pattern[c][63:32] <= wr_val;
						wtm_pkg::MKW_PAT_LEN: mk_pat_len[c] <=
							7'(clamp(wr_val, wtm_pkg::PAT_LEN_MIN, wtm_pkg::PAT_LEN_MAX));
						wtm_pkg::MKW_DIVIDER: mk_divider[c] <=
							11'(clamp(wr_val, wtm_pkg::DIV_MIN, wtm_pkg::DIV_MAX));
						wtm_pkg::MKW_DELAY: mk_delay[c] <= wr_val[23:0];
						default: begin
						end
					endcase
				end
			end
		end
	end

	// Delay in cycles; the fraction of a sample cannot be applied at clock level,
	// so the applied-delay readout leaves it out as well
	always_comb begin
		if (unit_time) begin
			delay_cyc = clamp(time_unit_delay / 32'(wtm_pkg::CLK_PERIOD_NS), 32'h0000_0000,
				wtm_pkg::DLY_MAX_CYC);
			applied_delay_seconds = 40'(delay_cyc) * 40'(wtm_pkg::QNS_PER_CYC);
		end else begin
			delay_cyc = {7'h00, delay_whole};
			applied_delay_seconds = 40'(delay_cyc) * 40'(wtm_pkg::QNS_PER_CYC);
		end
	end

	// Two-stage synchroniser, edge taken from the second stage only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= ext_trigger_pin;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// External edges arriving during a running delay are dropped
	wtm_countdown #(.W(32)) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(ext_sync && !ext_prev && !dly_busy),
		.value(delay_cyc),
		.busy(dly_busy),
		.done(dly_done)
	);

	wtm_countdown #(.W(32)) u_holdoff (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(next_restart),
		.value(holdoff),
		.busy(inh_busy),
		.done()
	);

	wtm_countdown #(.W(32)) u_single (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(next_state == wtm_pkg::ST_RUN && state != wtm_pkg::ST_RUN
			&& trig_mode == wtm_pkg::TM_SINGLE),
		.value(32'(SINGLE_LEN - 1)),
		.busy(),
		.done(single_done)
	);

	// Playback control; arm beats a trigger, a mode change restarts the sequence
	always_comb begin
		next_state = state;
		next_restart = 1'b0;
		case (state)
			wtm_pkg::ST_START: begin
				if (trig_mode == wtm_pkg::TM_AUTO || trig_mode == wtm_pkg::TM_RETRIGGER) begin
					next_state = wtm_pkg::ST_RUN;
					next_restart = 1'b1;
				end else begin
					next_state = wtm_pkg::ST_ARMED;
				end
			end
			wtm_pkg::ST_ARMED: begin
				if ((manual_cmd || dly_done) && !inh_busy) begin
					next_state = wtm_pkg::ST_RUN;
					next_restart = sync_output_enable;
				end
			end
			wtm_pkg::ST_RUN: begin
				if (trig_mode == wtm_pkg::TM_SINGLE && single_done) begin
					next_state = wtm_pkg::ST_ARMED;
				end else if ((manual_cmd || dly_done) && !inh_busy && sync_output_enable
					&& (trig_mode == wtm_pkg::TM_RETRIGGER
					|| trig_mode == wtm_pkg::TM_ARMED_REARM)) begin
					next_restart = 1'b1;
				end
			end
			default: next_state = wtm_pkg::ST_START;
		endcase
		if (arm_cmd) begin
			next_state = wtm_pkg::ST_ARMED;
			next_restart = 1'b0;
		end
		if (mode_write) begin
			next_state = wtm_pkg::ST_START;
			next_restart = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= wtm_pkg::ST_START;
			play_run <= 1'b0;
			play_restart <= 1'b0;
		end else begin
			state <= next_state;
			play_run <= next_state == wtm_pkg::ST_RUN;
			play_restart <= next_restart;
		end
	end

	// One generator per marker output
	for (genvar g = 0; g < NMARK; g++) begin : g_marker
		wtm_marker #(.PW(24)) u_marker (
			.aclk(aclk),
			.aresetn(aresetn),
			.mode(mk_mode[g]),
			.high_period_samples(high_period_samples[g]),
			.low_period_samples(low_period_samples[g]),
			.pattern(mk_pattern[g]),
			.pat_len(mk_pat_len[g]),
			.divider(mk_divider[g]),
			.start_delay(mk_delay[g]),
			.restart(play_restart),
			.running(play_run),
			.waveform_bit(waveform_defined_marker[g]),
			.marker(marker_out[g])
		);
	end
endmodule

// ===== tb/wtm_top_sva.sv
/* Port checker for wtm_top: bus answers, restart pulse, marker idling.
 Bound to every wtm_top; one clock, synchronous active-low reset. */
`timescale 1ns/1ns
module wtm_top_chk #(
	parameter int NMARK = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NMARK-1:0] marker_out,
	input wire logic play_run,
	input wire logic play_restart
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Restart is a lone pulse that always comes with running output
	a_restart_pulse: assert property (play_restart |=> !play_restart)
		else $error("restart pulse too wide");
	a_restart_runs: assert property (play_restart |-> play_run)
		else $error("restart without running output");
	// Bus answers follow the taking edge and stand until taken
	a_write_answer: assert property (s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid)
		else $error("write not answered");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	// Flops in the marker path lag play_run, so give it three cycles
	a_marker_idle: assert property (!play_run [*3] |-> marker_out == '0)
		else $error("marker active while stopped");
	cover property (play_restart);
	cover property (|marker_out);
	cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind wtm_top wtm_top_chk #(.NMARK(NMARK)) u_chk (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .marker_out, .play_run, .play_restart);

// ===== tb/tb.sv
/* Self-checking bench for wtm_top: registers, triggers, hold-off, markers.
 Drives every input itself at a 20 MHz clock; checker bound separately. */
`timescale 1ns/1ns
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, pin = 1'b0;
	logic [2:0] wfm = 3'h0;
	logic awr, wr_, bv, arr, rv, run, rst;
	logic [1:0] br, rr;
	logic [31:0] rdata;
	logic [2:0] mk;
	int num_errors = 0;
	int cmp_count = 0;
	wtm_top #(.SINGLE_LEN(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.ext_trigger_pin(pin), .waveform_defined_marker(wfm), .marker_out(mk),
		.play_run(run), .play_restart(rst));
	initial begin
		forever #25 aclk = ~aclk;
	end
	task automatic complete_run();
		if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Bready and rready come late on purpose so the answer must stand
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do @(posedge aclk); while (awr !== 1'b1);
		awv <= 1'b0;
		wv <= 1'b0;
		repeat (2) @(posedge aclk);
		bry <= 1'b1;
		do @(posedge aclk); while (bv !== 1'b1);
		r = br;
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arv <= 1'b1;
		do @(posedge aclk); while (arr !== 1'b1);
		arv <= 1'b0;
		repeat (2) @(posedge aclk);
		rry <= 1'b1;
		do @(posedge aclk); while (rv !== 1'b1);
		d = rdata;
		rry <= 1'b0;
	endtask
	// Counts restart pulses, first pulse position and marker high cycles
	task automatic watch(input int n, output int c, f, output int h[3]);
		c = 0;
		f = -1;
		h = '{0, 0, 0};
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			if (rst === 1'b1) begin
				if (f < 0) f = i;
				c++;
			end
			for (int k = 0; k < 3; k++) if (mk[k] === 1'b1) h[k]++;
		end
	endtask
	task automatic t_regs();
		logic [7:0] ra[14] = '{8'h00, 8'h10, 8'h18, 8'h1C, 8'h40, 8'h44, 8'h48, 8'h4C,
			8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h64};
		logic [31:0] re[14] = '{32'h1, 32'h0, 32'hFA, 32'h0, 32'h0, 32'h1, 32'h1, 32'h2,
			32'h0, 32'h2, 32'h2, 32'h0, 32'h0098_9680, 32'h0};
		logic [7:0] wa[11] = '{8'h58, 8'h58, 8'h58, 8'h44, 8'h48, 8'h54, 8'h40, 8'h5C,
			8'h08, 8'h00, 8'h0C};
		logic [31:0] wd[11] = '{32'h1, 32'h7D0, 32'h5, 32'h0, 32'hFFFF_FFFF, 32'h41,
			32'h5, 32'h3, 32'h2E3, 32'h3, 32'h208};
		logic [7:0] qa[11] = '{8'h58, 8'h60, 8'h60, 8'h44, 8'h48, 8'h54, 8'h40, 8'h64,
			8'h1C, 8'h00, 8'h1C};
		logic [31:0] qe[11] = '{32'h2, 32'h4C4B, 32'h003D_0900, 32'h1, 32'h00E3_8E37,
			32'h40, 32'h0, 32'h96, 32'h3E8, 32'h3, 32'h7D0};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 14; i++) begin
			rd(ra[i], d);
			chk(d, re[i]);
		end
		for (int i = 0; i < 11; i++) begin
			wr(wa[i], wd[i], r);
			rd(qa[i], d);
			chk(d, qe[i]);
		end
		wr(8'h30, 32'h1, r);
		chk(r, 2'h2);
		rd(8'h30, d);
		chk(rr, 2'h2);
		chk(d, 32'h0);
	endtask
	task automatic ext(output int f);
		int c, h[3];
		logic [1:0] r;
		wr(8'h04, 32'h2, r);
		fork
			begin
				@(posedge aclk);
				pin <= 1'b1;
				repeat (3) @(posedge aclk);
				pin <= 1'b0;
			end
			watch(60, c, f, h);
		join
		chk(c, 1);
	endtask
	// Delay differences cancel the fixed path, leaving only counter length
	task automatic t_ext();
		int f1, f2, f3;
		logic [1:0] r;
		ext(f1);
		wr(8'h0C, 32'h3E8, r);
		ext(f2);
		chk(f2 - f1, 10);
		wr(8'h00, 32'h1, r);
		ext(f3);
		chk(f1 - f3, 5);
	endtask
	task automatic trig(input int hold, input int exp);
		int c, f, h[3];
		logic [1:0] r;
		wr(8'h10, hold, r);
		repeat (60) @(posedge aclk);
		fork
			begin
				wr(8'h04, 32'h1, r);
				wr(8'h04, 32'h1, r);
			end
			watch(30, c, f, h);
		join
		chk(c, exp);
	endtask
	task automatic t_trig();
		int c, f, h[3];
		logic [31:0] d;
		logic [1:0] r;
		for (int m = 0; m < 5; m++) begin
			wr(8'h00, (m << 4) | 1, r);
			repeat (4) @(posedge aclk);
			rd(8'h14, d);
			chk(d[1:0], (m >= 2) ? 2'h2 : 2'h1);
		end
		wr(8'h00, 32'h11, r);
		trig(40, 1);
		trig(0, 2);
		wr(8'h00, 32'h0, r);
		wr(8'h04, 32'h2, r);
		fork
			wr(8'h04, 32'h1, r);
			watch(20, c, f, h);
		join
		chk({c[30:0], run}, 32'h1);
	endtask
	task automatic t_mark();
		logic [7:0] a[10] = '{8'h40, 8'h44, 8'h48, 8'h80, 8'h98, 8'hC0, 8'hCC, 8'hD4,
			8'h5C, 8'h00};
		logic [31:0] v[10] = '{32'h4, 32'h3, 32'h2, 32'h2, 32'h4, 32'h3, 32'h5, 32'h3,
			32'h0, 32'h11};
		int c, f, h[3];
		logic [1:0] r;
		for (int i = 0; i < 10; i++) wr(a[i], v[i], r);
		repeat (20) @(posedge aclk);
		watch(60, c, f, h);
		chk(h[0], 36);
		chk(h[1], 30);
		chk(h[2], 40);
		wr(8'h40, 32'h0, r);
		for (int i = 0; i < 4; i++) begin
			wfm <= {2'b00, i[0]};
			repeat (3) @(posedge aclk);
			chk(mk[0], i[0]);
		end
		// Restart source: one pulse per manual retrigger
		wr(8'h80, 32'h1, r);
		fork
			wr(8'h04, 32'h1, r);
			watch(20, c, f, h);
		join
		chk(h[1], 1);
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_ext();
		t_trig();
		t_mark();
		complete_run();
	end
	// Whole run needs about a thousand cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		complete_run();
	end
endmodule
